// File: shared/ofad_map.vh
// Purpose: register offsets, field positions, reset values and state counts
// Assumes: AHB-Lite byte addresses, one 32-bit word per register
// Notes: included by the operand and add decoder files
`ifndef OFAD_MAP_VH
`define OFAD_MAP_VH

// register byte offsets
`define OFAD_OFF_FEED      12'h000
`define OFAD_OFF_STATUS    12'h004
`define OFAD_OFF_ACCF      12'h008
`define OFAD_OFF_FIRST     12'h00c
`define OFAD_OFF_SECOND    12'h010
`define OFAD_OFF_MPTR      12'h014
`define OFAD_OFF_IDX1      12'h018
`define OFAD_OFF_IDX2      12'h01c
`define OFAD_OFF_STACK     12'h020
`define OFAD_OFF_PROBE     12'h024
`define OFAD_OFF_PROBE_PR  12'h028
`define OFAD_OFF_PROBE_DSP 12'h02c
`define OFAD_OFF_MEM_LO    12'h100
`define OFAD_OFF_MEM_HI    12'h1fc

// flag byte positions
`define OFAD_FLG_S  7
`define OFAD_FLG_Z  6
`define OFAD_FLG_H  4
`define OFAD_FLG_PV 2
`define OFAD_FLG_N  1
`define OFAD_FLG_C  0

// status bit positions
`define OFAD_ST_ILLEGAL 3

// reset values
`define OFAD_RST_BYTE 8'h00
`define OFAD_RST_WORD 16'h0000

// opcode and prefix bytes
`define OFAD_PFX_IDX1  8'hdd
`define OFAD_PFX_IDX2  8'hfd
`define OFAD_GRP_ADD   5'b10000
`define OFAD_GRP_ADC   5'b10001
`define OFAD_IMM_ADD   8'hc6
`define OFAD_IMM_ADC   8'hce
`define OFAD_MEM_CODE  3'b110

// state counts per form
`define OFAD_STATES_REG 5'd4
`define OFAD_STATES_MEM 5'd6
`define OFAD_STATES_IMM 5'd6
`define OFAD_STATES_IDX 5'd14

`endif

// File: test/ofad_prog_mem.sv
// Purpose: program memory that hands instruction bytes to the bench
// Assumes: one request at a time, held until ack
// Notes: lat sets how many cycles it stalls before answering
`timescale 1ns/10ps
module ofad_prog_mem (
  input  wire        clk,
  input  wire        req,
  input  wire  [7:0] addr,
  input  wire  [1:0] lat,
  output logic [7:0] rdata,
  output logic       ack
);
  logic [7:0] mem [256];
  int         cnt = 0;
  initial begin
    ack = 1'b0;
    rdata = 8'h5a;
  end
  task load(input logic [7:0] a, input logic [7:0] d);
    mem[a] = d;
  endtask
  always @(posedge clk) begin
    if (req && !ack && cnt >= lat) begin
      ack <= 1'b1;
      rdata <= mem[addr];
      cnt <= 0;
    end else begin
      ack <= 1'b0;
      cnt <= req ? cnt + 1 : 0;
      // released bus keeps toggling so a stale byte is never seen
      rdata <= ~rdata;
    end
  end
endmodule // ofad_prog_mem

// File: test/ofad_top_sva.sv
// Purpose: port assertions for the operand and add decoder
// Assumes: zero wait slave, add results follow a feed byte
// Notes: bound to ofad_top at the foot
`timescale 1ns/10ps
`include "ofad_map.vh"
module ofad_top_sva (
  input wire        clk,
  input wire        rst,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire [31:0] hrdata,
  input wire        hreadyout,
  input wire        hresp,
  input wire [7:0]  acc,
  input wire [7:0]  flags
);
  logic       dp_acc;
  logic       dp_feed;
  logic [4:0] since;
  wire        take = hsel && hready && htrans[1];
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      dp_acc <= 1'b0;
      dp_feed <= 1'b0;
      since <= 5'h1f;
    end else begin
      dp_acc <= take && hwrite && haddr[11:0] == `OFAD_OFF_ACCF;
      dp_feed <= take && hwrite && haddr[11:0] == `OFAD_OFF_FEED;
      since <= dp_feed ? 5'h00 : since + {4'h0, since != 5'h1f};
    end
  end
  // an add result is a change of acc or flags not caused by a bus write
  property p_add(x);
    ($changed(acc) || $changed(flags)) && !$past(dp_acc) |-> x;
  endproperty
  a_ready_zero_wait: assert property (hreadyout) else $error("hreadyout low");
  a_resp_okay: assert property (!hresp) else $error("error response");
  a_read_data_hold: assert property (!(take && !hwrite) |=> $stable(hrdata))
    else $error("hrdata moved");
  a_exec_state_count: assert property (p_add(since == 5'h04 || since == 5'h06 || since == 5'h0e))
    else $error("result at wrong count");
  a_sign_from_result: assert property (p_add(flags[`OFAD_FLG_S] == acc[7]))
    else $error("sign flag wrong");
  a_zero_from_result: assert property (p_add(flags[`OFAD_FLG_Z] == (acc == 8'h00)))
    else $error("zero flag wrong");
  a_subtract_clear: assert property (p_add(!flags[`OFAD_FLG_N]))
    else $error("subtract flag set");
  a_spare_bits_clear: assert property (p_add(!flags[5] && !flags[3]))
    else $error("spare flag bits set");
  cover property (dp_feed);
  cover property (since == 5'h0e && $changed(acc));
  cover property (take && !hwrite);
endmodule // ofad_top_sva

bind ofad_top ofad_top_sva u_ofad_top_sva (.clk, .rst, .hsel, .haddr, .htrans, .hwrite,
  .hready, .hrdata, .hreadyout, .hresp, .acc, .flags);

// File: test/test_ofad_top.sv
// Purpose: self-checking bench for the operand and add decoder
// Assumes: zero wait AHB-Lite slave, 10 MHz clock
// Notes: expectations come from an integer model kept here
`timescale 1ns/10ps
`include "ofad_map.vh"
module test_ofad_top;
  logic        clk = 0, rst = 1, hsel = 0, hwrite = 0, preq = 0;
  logic [31:0] haddr = 0, hwdata = 0, rd;
  logic [1:0]  htrans = 0, plat = 0;
  logic [7:0]  paddr = 0;
  logic [7:0]  q[$];
  wire  [31:0] hrdata;
  wire  [7:0]  acc, flags, prd;
  wire         hreadyout, hresp, pack;
  int          failures = 0, tests_run = 0, seed, a, f, p[6], m[64];
  always #50 clk = ~clk;
  ofad_top u_ofad_top (.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .acc, .flags);
  ofad_prog_mem u_ofad_prog_mem (.clk, .req(preq), .addr(paddr), .lat(plat), .rdata(prd),
    .ack(pack));
  task print_verdict;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task check(string n, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task tmo(int n);
    if (n >= 50) begin
      failures++;
      print_verdict;
    end
  endtask
  task automatic ahb(logic w, logic [11:0] ad, logic [31:0] wd, output logic [31:0] r);
    int n = 0;
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {20'h0, ad};
    do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 50);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
    do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 50);
    r = hrdata;
    tmo(n);
  endtask
  task automatic feed_q;
    logic [7:0] b;
    int n;
    foreach (q[i]) begin
      u_ofad_prog_mem.load(8'(i), q[i]);
      n = 0;
      preq <= 1'b1; paddr <= 8'(i);
      do begin @(posedge clk); n++; end while (pack !== 1'b1 && n < 50);
      b = prd;
      preq <= 1'b0;
      tmo(n);
      ahb(1, `OFAD_OFF_FEED, {24'h0, b}, rd);
    end
  endtask
  function automatic int reg8(int g);
    return g == 7 ? a : (p[g / 2] >> (g % 2 ? 0 : 8)) & 255;
  endfunction
  function automatic void exp_add(int b, int c);
    int s = a + b + c;
    int h = (a & 15) + (b & 15) + c;
    f = (s & 128) | ((s & 255) == 0) << 6 | (h > 15) << 4 | (s > 255);
    f = f | ((~(a ^ b) & (a ^ s) & 128) ? 4 : 0);
    a = s & 255;
  endfunction
  initial begin
    int c, x, d, op, opnd, g, pc, fm, bt, pos, pp, n;
    seed = $urandom(81369);
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    ahb(0, `OFAD_OFF_ACCF, 0, rd);
    check("accf_reset", 0, rd);
    for (int i = 0; i < 6; i++) begin
      p[i] = $urandom & 16'hffff;
      ahb(1, 12'(`OFAD_OFF_FIRST + 4 * i), p[i], rd);
    end
    for (int i = 0; i < 64; i++) begin
      m[i] = $urandom & 255;
      ahb(1, 12'(`OFAD_OFF_MEM_LO + 4 * i), m[i], rd);
    end
    // 0..7 register or memory, 8 immediate, 9 and 10 indexed; plain then carry
    for (int k = 0; k < 22; k++) begin
      c = k / 11; x = k % 11; d = $urandom & 255;
      a = $urandom & 255; f = $urandom & 255;
      plat <= 2'(k);
      ahb(1, `OFAD_OFF_ACCF, a << 8 | f, rd);
      op = 8'h80 | c << 3 | (x < 8 ? x : 6);
      if (x < 8) q = '{8'(op)};
      else if (x == 8) q = '{8'(op | 8'h46), 8'(d)};
      else q = '{x == 9 ? `OFAD_PFX_IDX1 : `OFAD_PFX_IDX2, 8'(op), 8'(d)};
      opnd = x == 8 ? d : x > 8 ? m[(p[x - 6] + (d ^ 128) - 128) & 63] :
             x == 6 ? m[p[2] & 63] : reg8(x);
      exp_add(opnd, c & f);
      feed_q;
      n = 0;
      do begin ahb(0, `OFAD_OFF_STATUS, 0, rd); n++; end while (rd[2:0] !== 3'h0 && n < 50);
      tmo(n);
      check("length", q.size(), rd[5:4]);
      check("states", x == 6 || x == 8 ? 6 : x > 8 ? 14 : 4, rd[10:6]);
      check("acc", a, acc);
      check("flags", f, flags);
    end
    q = '{`OFAD_PFX_IDX1, 8'h80};
    feed_q;
    ahb(0, `OFAD_OFF_STATUS, 0, rd);
    check("illegal", 8, {rd[3], rd[2:0]});
    check("acc_kept", a, acc);
    ahb(1, `OFAD_OFF_STATUS, 8, rd);
    ahb(0, `OFAD_OFF_STATUS, 0, rd);
    check("illegal_clr", 0, rd[3]);
    for (int i = 0; i < 32; i++) begin
      g = i % 8; pc = i % 4; fm = i / 8; bt = (i + 3) % 8; d = $urandom & 255;
      ahb(1, `OFAD_OFF_PROBE, g | pc << 3 | fm << 5 | (i & 1) << 7 | bt << 8 | g << 11
          | (7 - g) << 16 | d << 24, rd);
      pos = g < 2 ? 6 : g < 4 ? 0 : g < 6 ? 2 : 7;
      ahb(0, `OFAD_OFF_PROBE, 0, rd);
      check("probe", (g == 6 ? 0 : reg8(g) | 256) | 1 << bt + 16
            | (((f >> pos) & 1) == (g & 1)) << 24 | (7 - g) << 28, rd & 32'hffff01ff);
      pp = pc < 2 ? p[pc] : pc == 2 ? (fm == 1 || fm == 2 ? p[fm + 2] : p[2]) :
           fm == 3 ? a << 8 | f : p[5];
      ahb(0, `OFAD_OFF_PROBE_PR, 0, rd);
      check("pair", pp | (i & 1 ? pp >> 8 : pp & 255) << 16, rd & 32'hffffff);
      ahb(0, `OFAD_OFF_PROBE_DSP, 0, rd);
      check("disp", (d ^ 128) - 128 & 16'hffff, rd & 32'hffff);
    end
    print_verdict;
  end
endmodule // test_ofad_top

// File: verilog/ofad_alu.v
// Purpose: 8-bit add with carry-in and flag byte
// Assumes: combinational, result used by the sequencer at the end of execution
// Notes: undocumented flag bits 5 and 3 are forced to zero
`timescale 1ns/10ps
`include "ofad_map.vh"
module ofad_alu (
  input  wire [7:0] a,
  input  wire [7:0] b,
  input  wire       cin,
  output wire [7:0] sum,
  output reg  [7:0] flags
);
  wire [8:0] full;
  wire [4:0] half;

  assign full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
  assign half = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
  assign sum  = full[7:0];

  always @* begin
    flags                 = 8'h00;
    flags[`OFAD_FLG_S]    = full[7];
    flags[`OFAD_FLG_Z]    = (full[7:0] == 8'h00);
    flags[`OFAD_FLG_H]    = half[4];
    flags[`OFAD_FLG_PV]   = (a[7] == b[7]) && (full[7] != a[7]);
    flags[`OFAD_FLG_N]    = 1'b0;
    flags[`OFAD_FLG_C]    = full[8];
  end
endmodule // ofad_alu

// File: verilog/ofad_top.v
// Purpose: operand field decoder and 8-bit add / add-with-carry executor
// Assumes: single clock, instruction bytes written one at a time over AHB-Lite
// Notes: memory operands come from a 64-byte window, addressed by low address bits
// Function
// - a 3-bit single-register code selects b, c, d, e, h, l or the accumulator, and 110 selects none.
// - a general pair code selects first pair, second pair, memory pointer or index register, or stack pointer.
// - in the stack-ops pair form code 10 is the memory pointer and 11 the accumulator-flags pair.
// - a half select on a pair reads the upper or lower eight bits of that pair.
// - the 3-bit bit field is the binary index of the target bit 0 to 7.
// - the condition field decodes to not zero, zero, no carry, carry, parity odd, parity even, plus, minus.
// - the restart field maps to eight targets spaced eight apart from 00h to 38h.
// - displacements are signed 8-bit, immediates are 8-bit data and two-byte immediates 16-bit.
// - register add is one byte in 4 states, immediate add is two bytes in 6 states.
// - add from memory at the memory pointer is one byte in 6 states.
// - first index prefix add adds the byte at index plus displacement, three bytes, 14 states.
// - second index prefix add does the same with the second index register.
// - add-with-carry forms add operand plus carry with the same lengths and state counts.
// - indexed add-with-carry works with either prefix, three bytes, 14 states.
// - the flag byte layout is fixed, overflow goes to parity/overflow and subtract is cleared.
//
// Decided for this implementation: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`include "ofad_map.vh"
module ofad_top (
  input  wire        clk,
  input  wire        rst,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  output reg  [7:0]  acc,
  output reg  [7:0]  flags
);
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_OP   = 3'd1;
  localparam [2:0] ST_DISP = 3'd2;
  localparam [2:0] ST_IMM  = 3'd3;
  localparam [2:0] ST_EXEC = 3'd4;

  reg  [15:0] first_pair;
  reg  [15:0] second_pair;
  reg  [15:0] memory_pointer_pair;
  reg  [15:0] first_index_register;
  reg  [15:0] second_index_register;
  reg  [15:0] stack_pointer;
  reg  [7:0]  mem [0:63];

  reg  [2:0]  state;
  reg  [4:0]  cnt;
  reg         use_carry;
  reg         idx_sel;
  reg  [7:0]  operand;
  reg  [7:0]  op_byte;
  reg         illegal;
  reg  [1:0]  last_len;
  reg  [4:0]  last_states;
  reg  [31:0] probe;

  reg         wr_pend;
  reg  [11:0] wr_addr;
  reg  [31:0] rd_word;

  wire        take;
  wire        exec_done;
  wire        feed_wr;
  wire [7:0]  feed_byte;
  wire [8:0]  feed_reg;
  wire [15:0] probe_pair;
  wire [7:0]  alu_sum;
  wire [7:0]  alu_flags;
  wire [15:0] idx_base;
  wire [15:0] eff_addr;
  wire        add_grp;
  wire        imm_grp;
  wire        clr_illegal;

  // single-register decode, code 110 has no register
  function [8:0] reg8;
    input [2:0] code;
    begin
      case (code)
        3'b000:  reg8 = {1'b1, first_pair[15:8]};
        3'b001:  reg8 = {1'b1, first_pair[7:0]};
        3'b010:  reg8 = {1'b1, second_pair[15:8]};
        3'b011:  reg8 = {1'b1, second_pair[7:0]};
        3'b100:  reg8 = {1'b1, memory_pointer_pair[15:8]};
        3'b101:  reg8 = {1'b1, memory_pointer_pair[7:0]};
        3'b111:  reg8 = {1'b1, acc};
        default: reg8 = 9'h000;
      endcase
    end
  endfunction

  // pair decode; form 0 general, 1 first index, 2 second index, 3 stack ops
  function [15:0] pair16;
    input [1:0] code;
    input [1:0] form;
    begin
      case (code)
        2'b00:   pair16 = first_pair;
        2'b01:   pair16 = second_pair;
        2'b10: begin
          case (form)
            2'd1:    pair16 = first_index_register;
            2'd2:    pair16 = second_index_register;
            default: pair16 = memory_pointer_pair;
          endcase
        end
        default: pair16 = (form == 2'd3) ? {acc, flags} : stack_pointer;
      endcase
    end
  endfunction

  // condition test against the current flag byte
  function cond_met;
    input [2:0] f;
    begin
      case (f[2:1])
        2'b00:   cond_met = flags[`OFAD_FLG_Z]  == f[0];
        2'b01:   cond_met = flags[`OFAD_FLG_C]  == f[0];
        2'b10:   cond_met = flags[`OFAD_FLG_PV] == f[0];
        default: cond_met = flags[`OFAD_FLG_S]  == f[0];
      endcase
    end
  endfunction

  // address decode, used by both read and write paths
  function [3:0] reg_index;
    input [11:0] a;
    begin
      case (a)
        `OFAD_OFF_FEED:      reg_index = 4'h1;
        `OFAD_OFF_STATUS:    reg_index = 4'h2;
        `OFAD_OFF_ACCF:      reg_index = 4'h3;
        `OFAD_OFF_FIRST:     reg_index = 4'h4;
        `OFAD_OFF_SECOND:    reg_index = 4'h5;
        `OFAD_OFF_MPTR:      reg_index = 4'h6;
        `OFAD_OFF_IDX1:      reg_index = 4'h7;
        `OFAD_OFF_IDX2:      reg_index = 4'h8;
        `OFAD_OFF_STACK:     reg_index = 4'h9;
        `OFAD_OFF_PROBE:     reg_index = 4'ha;
        `OFAD_OFF_PROBE_PR:  reg_index = 4'hb;
        `OFAD_OFF_PROBE_DSP: reg_index = 4'hc;
        default: reg_index = (a >= `OFAD_OFF_MEM_LO && a <= `OFAD_OFF_MEM_HI) ? 4'hd : 4'h0;
      endcase
    end
  endfunction

  assign take        = hsel & hready & htrans[1];
  assign feed_wr     = wr_pend && (reg_index(wr_addr) == 4'h1);
  assign feed_byte   = hwdata[7:0];
  assign feed_reg    = reg8(feed_byte[2:0]);
  assign probe_pair  = pair16(probe[4:3], probe[6:5]);
  assign clr_illegal = wr_pend && (reg_index(wr_addr) == 4'h2) && hwdata[`OFAD_ST_ILLEGAL];
  assign exec_done   = (state == ST_EXEC) && (cnt == 5'd1);
  assign add_grp     = (feed_byte[7:3] == `OFAD_GRP_ADD) || (feed_byte[7:3] == `OFAD_GRP_ADC);
  assign imm_grp     = (feed_byte == `OFAD_IMM_ADD) || (feed_byte == `OFAD_IMM_ADC);
  assign idx_base    = idx_sel ? second_index_register : first_index_register;
  assign eff_addr    = idx_base + {{8{feed_byte[7]}}, feed_byte};

  ofad_alu u_alu (
    .a     (acc),
    .b     (operand),
    .cin   (use_carry & flags[`OFAD_FLG_C]),
    .sum   (alu_sum),
    .flags (alu_flags)
  );

  // decode sequencer; feed bytes during execution are dropped
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state       <= ST_IDLE;
      cnt         <= 5'd0;
      use_carry   <= 1'b0;
      idx_sel     <= 1'b0;
      operand     <= `OFAD_RST_BYTE;
      op_byte     <= `OFAD_RST_BYTE;
      illegal     <= 1'b0;
      last_len    <= 2'd0;
      last_states <= 5'd0;
    end else begin
      if (clr_illegal)
        illegal <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (feed_wr) begin
            if (feed_byte == `OFAD_PFX_IDX1 || feed_byte == `OFAD_PFX_IDX2) begin
              idx_sel <= (feed_byte == `OFAD_PFX_IDX2);
              state   <= ST_OP;
            end else if (add_grp) begin
              use_carry <= feed_byte[3];
              last_len  <= 2'd1;
              state     <= ST_EXEC;
              if (feed_byte[2:0] == `OFAD_MEM_CODE) begin
                operand     <= mem[memory_pointer_pair[5:0]];
                cnt         <= `OFAD_STATES_MEM;
                last_states <= `OFAD_STATES_MEM;
              end else begin
                operand     <= feed_reg[7:0];
                cnt         <= `OFAD_STATES_REG;
                last_states <= `OFAD_STATES_REG;
              end
            end else if (imm_grp) begin
              use_carry <= feed_byte[3];
              state     <= ST_IMM;
            end else begin
              illegal <= 1'b1;
            end
          end
        end
        ST_OP: begin
          if (feed_wr) begin
            if (add_grp && feed_byte[2:0] == `OFAD_MEM_CODE) begin
              use_carry <= feed_byte[3];
              state     <= ST_DISP;
            end else begin
              illegal <= 1'b1;
              state   <= ST_IDLE;
            end
          end
        end
        ST_DISP: begin
          if (feed_wr) begin
            operand     <= mem[eff_addr[5:0]];
            cnt         <= `OFAD_STATES_IDX;
            last_states <= `OFAD_STATES_IDX;
            last_len    <= 2'd3;
            state       <= ST_EXEC;
          end
        end
        ST_IMM: begin
          if (feed_wr) begin
            operand     <= feed_byte;
            cnt         <= `OFAD_STATES_IMM;
            last_states <= `OFAD_STATES_IMM;
            last_len    <= 2'd2;
            state       <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          cnt <= cnt - 5'd1;
          if (exec_done)
            state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
      // a new fault in the clearing cycle must survive the clear
      if (feed_wr && ((state == ST_IDLE && !add_grp && !imm_grp &&
          feed_byte != `OFAD_PFX_IDX1 && feed_byte != `OFAD_PFX_IDX2) ||
          (state == ST_OP && !(add_grp && feed_byte[2:0] == `OFAD_MEM_CODE))))
        illegal <= 1'b1;
    end
  end

  // register file; completion of an add beats a bus write to the accumulator
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      acc                   <= `OFAD_RST_BYTE;
      flags                 <= `OFAD_RST_BYTE;
      first_pair            <= `OFAD_RST_WORD;
      second_pair           <= `OFAD_RST_WORD;
      memory_pointer_pair   <= `OFAD_RST_WORD;
      first_index_register  <= `OFAD_RST_WORD;
      second_index_register <= `OFAD_RST_WORD;
      stack_pointer         <= `OFAD_RST_WORD;
      probe                 <= 32'h00000000;
    end else begin
      if (wr_pend) begin
        case (reg_index(wr_addr))
          4'h3: begin
            acc   <= hwdata[15:8];
            flags <= hwdata[7:0];
          end
          4'h4: first_pair            <= hwdata[15:0];
          4'h5: second_pair           <= hwdata[15:0];
          4'h6: memory_pointer_pair   <= hwdata[15:0];
          4'h7: first_index_register  <= hwdata[15:0];
          4'h8: second_index_register <= hwdata[15:0];
          4'h9: stack_pointer         <= hwdata[15:0];
          4'ha: probe                 <= hwdata;
          default: ;
        endcase
      end
      if (exec_done) begin
        acc   <= alu_sum;
        flags <= alu_flags;
      end
    end
  end

  // memory window, low byte of each word
  always @(posedge clk) begin
    if (wr_pend && reg_index(wr_addr) == 4'hd)
      mem[wr_addr[7:2]] <= hwdata[7:0];
  end

  // read mux; probe fields: g[2:0] pair[4:3] form[6:5] half[7] bit[10:8]
  // cond[13:11] restart[18:16] disp[31:24]
  always @* begin
    rd_word = 32'h00000000;
    case (reg_index(haddr[11:0]))
      4'h2: rd_word = {21'h00000, last_states, last_len, illegal, state};
      4'h3: rd_word = {16'h0000, acc, flags};
      4'h4: rd_word = {16'h0000, first_pair};
      4'h5: rd_word = {16'h0000, second_pair};
      4'h6: rd_word = {16'h0000, memory_pointer_pair};
      4'h7: rd_word = {16'h0000, first_index_register};
      4'h8: rd_word = {16'h0000, second_index_register};
      4'h9: rd_word = {16'h0000, stack_pointer};
      4'ha: begin
        rd_word[8:0]   = reg8(probe[2:0]);
        rd_word[15:9]  = 7'h00;
        rd_word[23:16] = 8'h01 << probe[10:8];
        rd_word[24]    = cond_met(probe[13:11]);
        rd_word[31:25] = {1'b0, probe[18:16], 3'b000};
      end
      4'hb: begin
        rd_word[15:0]  = probe_pair;
        rd_word[23:16] = probe[7] ? probe_pair[15:8] : probe_pair[7:0];
      end
      4'hc: rd_word = {16'h0000, {8{probe[31]}}, probe[31:24]};
      4'hd: rd_word = {24'h000000, mem[haddr[7:2]]};
      default: rd_word = 32'h00000000;
    endcase
  end

  // zero-wait slave: reads are staged in the address phase
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_pend   <= 1'b0;
      wr_addr   <= 12'h000;
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend   <= take & hwrite;
      if (take)
        wr_addr <= haddr[11:0];
      if (take && !hwrite)
        hrdata <= rd_word;
    end
  end
endmodule // ofad_top
